// file: led_fade_pkg.sv
package led_fade_pkg;

	// Timing base.
	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned DEBOUNCE_US    = 10;
	localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
	localparam int unsigned STEP_UNIT_NS   = 1000;
	localparam int unsigned STEP_UNIT_CYC  = (STEP_UNIT_NS * CLK_MHZ + 999) / 1000;

	// Ramp geometry.
	localparam logic [5:0]  STEP_LAST      = 6'h3f;
	localparam logic [5:0]  STEP_FIRST     = 6'h00;
	localparam logic [7:0]  TIME_DISABLE   = 8'h00;

	// Reset values.
	localparam logic [7:0]  LEVEL_RST      = 8'h00;
	localparam logic        LATCH_RST      = 1'b0;
	localparam logic        PIN_IDLE_RST   = 1'b1;

	typedef struct packed {
		logic [7:0] rise_time_select;
		logic [7:0] fall_time_select;
		logic [7:0] current_level_set;
	} fade_cfg_s;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_UP,
		ST_ON,
		ST_DOWN
	} fade_state_e;

endpackage : led_fade_pkg

// file: led_fade_toggle_controller.sv
`timescale 1ns/10ps
module led_fade_toggle_controller
	import led_fade_pkg::*;
#(
	parameter bit DIM_ACTIVE_HIGH = 1'b1
) (
	// Clock and reset.
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	// Pins.
	input  wire logic       toggle_n_i,
	input  wire logic       dim_i,
	// Settings.
	input  wire fade_cfg_s  cfg_i,
	// Current source drive.
	output logic [7:0]      level_o,
	output logic            src_en_o,
	// Status.
	output logic            latch_o,
	output logic            ramping_o
);

	logic [2:0]  tog_sync_r;
	logic [2:0]  dim_sync_r;
	logic        tog_q_r;
	logic        dim_q_r;
	logic        deb_r;
	logic [10:0] deb_cnt_r;
	logic        toggle_evt;
	logic        latch_r;
	fade_state_e state_r;
	fade_state_e state_nxt;
	logic [5:0]  step_r;
	logic [5:0]  step_nxt;
	logic [15:0] tick_cnt_r;
	logic        step_tick;
	logic        dim_act;
	logic [7:0]  fade_level;
	logic [7:0]  level_r;
	logic        src_en_r;
	logic [15:0] step_age_r;

	function automatic logic [15:0] step_len(input logic [7:0] sel);
		logic [23:0] prod;
		prod = 24'(sel) * 24'(STEP_UNIT_CYC);
		return prod[15:0];
	endfunction : step_len

	// Square law approximation; the last step is forced to full scale.
	function automatic logic [7:0] gamma(input logic [5:0] idx, input logic [7:0] full);
		logic [11:0] sq;
		logic [15:0] sc;
		sq = 12'(idx) * 12'(idx);
		sc = 16'(sq[11:4]) * 16'(full);
		if (idx == STEP_LAST) begin
			return full;
		end
		return sc[15:8];
	endfunction : gamma

	// Three-stage pin capture; a change counts once stages two and three agree.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tog_sync_r <= {3{PIN_IDLE_RST}};
			dim_sync_r <= 3'h0;
			tog_q_r    <= PIN_IDLE_RST;
			dim_q_r    <= 1'b0;
		end else begin
			tog_sync_r <= {tog_sync_r[1:0], toggle_n_i};
			dim_sync_r <= {dim_sync_r[1:0], dim_i};
			if (tog_sync_r[1] == tog_sync_r[2]) begin
				tog_q_r <= tog_sync_r[2];
			end
			if (dim_sync_r[1] == dim_sync_r[2]) begin
				dim_q_r <= dim_sync_r[2];
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			deb_r     <= PIN_IDLE_RST;
			deb_cnt_r <= 11'h000;
		end else if (tog_q_r == deb_r) begin
			deb_cnt_r <= 11'h000;
		end else if (deb_cnt_r == 11'(DEBOUNCE_CYC - 1)) begin
			deb_r     <= tog_q_r;
			deb_cnt_r <= 11'h000;
		end else begin
			deb_cnt_r <= deb_cnt_r + 11'h001;
		end
	end

	// accepted falling edge is the toggle event.
	assign toggle_evt = deb_r && !tog_q_r && (deb_cnt_r == 11'(DEBOUNCE_CYC - 1));

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			latch_r <= LATCH_RST;
		end else if (toggle_evt) begin
			latch_r <= !latch_r;
		end
	end

	// step duration from the selected setting.
	always_comb begin
		step_tick = 1'b0;
		if (state_r == ST_UP) begin
			step_tick = tick_cnt_r == step_len(cfg_i.rise_time_select) - 16'h0001;
		end else if (state_r == ST_DOWN) begin
			step_tick = tick_cnt_r == step_len(cfg_i.fall_time_select) - 16'h0001;
		end
	end

	always_comb begin
		state_nxt = state_r;
		step_nxt  = step_r;
		case (state_r)
			ST_UP: begin
				if (step_tick) begin
					step_nxt = step_r + 6'h01;
					if (step_nxt == STEP_LAST) begin
						state_nxt = ST_ON;
					end
				end
			end
			ST_DOWN: begin
				if (step_tick) begin
					step_nxt = step_r - 6'h01;
					if (step_nxt == STEP_FIRST) begin
						state_nxt = ST_OFF;
					end
				end
			end
			default: begin
			end
		endcase
		if (toggle_evt) begin
			step_nxt = step_r;
			if (!latch_r) begin
				if (cfg_i.rise_time_select == TIME_DISABLE || step_r == STEP_LAST) begin
					state_nxt = ST_ON;
					step_nxt  = STEP_LAST;
				end else begin
					state_nxt = ST_UP;
				end
			end else begin
				if (cfg_i.fall_time_select == TIME_DISABLE || step_r == STEP_FIRST) begin
					state_nxt = ST_OFF;
					step_nxt  = STEP_FIRST;
				end else begin
					state_nxt = ST_DOWN;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_OFF;
			step_r  <= STEP_FIRST;
		end else begin
			state_r <= state_nxt;
			step_r  <= step_nxt;
		end
	end

	// per-direction step timer, restarted at each step or toggle.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_r <= 16'h0000;
		end else if (step_tick || toggle_evt || state_r == ST_OFF || state_r == ST_ON) begin
			tick_cnt_r <= 16'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// Cycles since the step index last moved or a toggle restarted the ramp timer.
	// It runs apart from the step timer so that the step length checks have a reference.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			step_age_r <= 16'h0000;
		end else if (toggle_evt || step_nxt != step_r) begin
			step_age_r <= 16'h0000;
		end else begin
			step_age_r <= step_age_r + 16'h0001;
		end
	end

	assign dim_act    = DIM_ACTIVE_HIGH ? dim_q_r : !dim_q_r;
	assign fade_level = gamma(step_r, cfg_i.current_level_set);

	// dimming drives the source only when idle off.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			level_r  <= LEVEL_RST;
			src_en_r <= 1'b0;
		end else if (state_r == ST_OFF) begin
			level_r  <= dim_act ? cfg_i.current_level_set : LEVEL_RST;
			src_en_r <= dim_act;
		end else begin
			level_r  <= fade_level;
			src_en_r <= step_r != STEP_FIRST;
		end
	end

	assign level_o   = level_r;
	assign src_en_o  = src_en_r;
	assign latch_o   = latch_r;
	assign ramping_o = (state_r == ST_UP) || (state_r == ST_DOWN);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_toggle_flip: assert property (toggle_evt |=> latch_r != $past(latch_r))
		else $error("latch did not flip on toggle");
	a_deb_restart: assert property ($changed(deb_r) |-> deb_cnt_r == 11'h000)
		else $error("debounce counter not restarted");
	a_on_full: assert property (state_r == ST_ON |-> step_r == STEP_LAST)
		else $error("on state below last step");
	a_down_step: assert property (state_r == ST_DOWN && step_tick && !toggle_evt
		|=> step_r == $past(step_r) - 6'h01)
		else $error("fade-out step wrong");
	a_interrupt_rev: assert property (toggle_evt && state_r == ST_UP
		&& cfg_i.fall_time_select != TIME_DISABLE && step_r != STEP_FIRST
		|=> state_r == ST_DOWN && step_r == $past(step_r))
		else $error("interrupt did not reverse in place");
	a_step_rate: assert property (state_r == ST_UP && step_tick && !toggle_evt
		|-> step_age_r == 16'(cfg_i.rise_time_select) * 16'(STEP_UNIT_CYC) - 16'h0001)
		else $error("fade-in step length wrong");
	a_fall_rate: assert property (state_r == ST_DOWN && step_tick && !toggle_evt
		|-> step_age_r == 16'(cfg_i.fall_time_select) * 16'(STEP_UNIT_CYC) - 16'h0001)
		else $error("fade-out step length wrong");
	a_instant_on: assert property (toggle_evt && !latch_r
		&& cfg_i.rise_time_select == TIME_DISABLE
		|=> state_r == ST_ON ##1 level_o == cfg_i.current_level_set)
		else $error("instant on failed");
	a_instant_off: assert property (toggle_evt && latch_r
		&& cfg_i.fall_time_select == TIME_DISABLE
		|=> state_r == ST_OFF && step_r == STEP_FIRST)
		else $error("instant off failed");
	a_dim_ignored: assert property (state_r == ST_ON
		|=> src_en_o && level_o == $past(cfg_i.current_level_set))
		else $error("dimming leaked into on state");
	a_dim_gate: assert property (state_r == ST_OFF |=> src_en_o == $past(dim_act))
		else $error("dimming not gating source");

	c_full_ramp: cover property (state_r == ST_UP ##1 state_r == ST_ON);
	c_ramp_down: cover property (state_r == ST_DOWN ##1 state_r == ST_OFF);
	c_interrupt: cover property (state_r == ST_UP && toggle_evt);
	c_dim_on: cover property (state_r == ST_OFF && src_en_o);

endmodule : led_fade_toggle_controller

// file: button_model.sv
`timescale 1ns/10ps
module button_model (
	input  wire logic mclk_i,
	input  wire logic go_i,
	output logic      toggle_n_o
);
	int cnt = 0;
	always_ff @(posedge mclk_i) begin
		if (go_i && cnt == 0) cnt <= 3000;
		else if (cnt != 0) cnt <= cnt - 1;
	end
	// High for 1500 cycles, then the contact bounces before it stays low.
	assign toggle_n_o = (cnt == 0) || (cnt > 1500) || (cnt > 1480 && cnt[1]);
endmodule : button_model

// file: test_led_fade_toggle_controller.sv
`timescale 1ns/10ps
module test_led_fade_toggle_controller;
	import led_fade_pkg::*;
	logic        mclk_i = 0;
	logic        rst_i = 1;
	logic        go = 0;
	logic        dim = 0;
	logic        tog_n;
	fade_cfg_s   cfg;
	logic [7:0]  level_o;
	logic        src_en_o, latch_o, ramping_o;
	logic [7:0]  level_lo;
	logic        src_en_lo;
	int          failures = 0;
	int          checks = 0;
	logic [31:0] r = 32'h769e;
	int          n;
	logic [7:0]  lv;
	led_fade_toggle_controller u_led_fade_toggle_controller (.mclk_i(mclk_i), .rst_i(rst_i),
		.toggle_n_i(tog_n), .dim_i(dim), .cfg_i(cfg), .level_o(level_o), .src_en_o(src_en_o),
		.latch_o(latch_o), .ramping_o(ramping_o));
	led_fade_toggle_controller #(.DIM_ACTIVE_HIGH(1'b0)) u_led_fade_toggle_controller_lo (
		.mclk_i(mclk_i), .rst_i(rst_i), .toggle_n_i(tog_n), .dim_i(dim), .cfg_i(cfg),
		.level_o(level_lo), .src_en_o(src_en_lo), .latch_o(), .ramping_o());
	button_model u_button_model (.mclk_i(mclk_i), .go_i(go), .toggle_n_o(tog_n));
	initial begin
		forever #4 mclk_i = ~mclk_i;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic press;
		go = 1;
		@(negedge mclk_i);
		go = 0;
		repeat (3002) @(negedge mclk_i);
	endtask : press
	task automatic wait_idle;
		n = 0;
		while (ramping_o !== 1'b0 && n < 20000) begin
			@(negedge mclk_i);
			n++;
		end
		// The level register follows the step index one cycle later.
		@(negedge mclk_i);
	endtask : wait_idle
	initial begin
		cfg = '{8'h00, 8'h00, 8'h80};
		repeat (6) @(negedge mclk_i);
		rst_i = 0;
		check("reset level", level_o, 8'h00);
		check("reset latch", latch_o, 1'b0);
		r = lfsr(r);
		cfg.current_level_set = r[15:8];
		for (int i = 0; i < 24; i++) begin
			r = lfsr(r);
			dim = r[0];
			repeat (6) @(negedge mclk_i);
			check("dim src_en", src_en_o, dim);
			check("dim level", level_o, dim ? cfg.current_level_set : 8'h00);
			check("dim low src_en", src_en_lo, !dim);
			check("dim low level", level_lo, dim ? 8'h00 : cfg.current_level_set);
		end
		dim = 0;
		press;
		check("instant on latch", latch_o, 1'b1);
		check("instant on level", level_o, cfg.current_level_set);
		for (int i = 0; i < 8; i++) begin
			dim = i[0];
			repeat (6) @(negedge mclk_i);
			check("on ignores dim", src_en_o, 1'b1);
		end
		dim = 0;
		cfg.fall_time_select = 8'h01;
		press;
		check("fade out ramping", ramping_o, 1'b1);
		check("fade out latch", latch_o, 1'b0);
		wait_idle;
		check("fade out level", level_o, 8'h00);
		check("fade out length", n > 7000 && n < 7875, 1'b1);
		cfg.rise_time_select = 8'h01;
		press;
		wait_idle;
		check("fade in level", level_o, cfg.current_level_set);
		check("fade in length", n > 7000 && n < 7875, 1'b1);
		cfg.fall_time_select = 8'h00;
		press;
		check("instant off", level_o, 8'h00);
		cfg.fall_time_select = 8'h01;
		cfg.rise_time_select = 8'h02;
		press;
		repeat (4000) @(negedge mclk_i);
		check("mid ramp", ramping_o, 1'b1);
		check("mid ramp level", level_o < cfg.current_level_set, 1'b1);
		press;
		lv = level_o;
		check("reversed latch", latch_o, 1'b0);
		check("reversed ramping", ramping_o, 1'b1);
		repeat (200) @(negedge mclk_i);
		check("reversed below", level_o < lv && level_o != 8'h00, 1'b1);
		wait_idle;
		check("reversed short", n > 100 && n < 4500, 1'b1);
		check("reversed level", level_o, 8'h00);
		stop_test;
	end
	initial begin
		#(8 * 90000);
		failures++;
		stop_test;
	end
endmodule : test_led_fade_toggle_controller
